// ### logic/sws_sequencer.sv
// Sleep/wake sequencer, sleep timer and watchdog
`timescale 1ns/1ps

// Operation
// - Clearing the power-on flag enables the watchdog; software cannot disable it.
// - Power-on reset disables the watchdog again.
// - Sleep timer runs from 32 kHz clock; overflow raises sleep interrupt.
// - Watchdog counts overflows and resets the part at three.
// - Any clear write zeroes watchdog; value 0x38 also clears sleep timer.
// - Sleep bit halts execution until interrupt pending with stop bit clear, or reset.
// - Any unmasked pending interrupt wakes unless stop bit set, global enable ignored.
// - Sleep forces internal core clock; software may switch back after wake.
// - Instruction after sleep runs before any interrupt service.
// - Sleep bit write asserts halt request at once.
// - Processor grants halt on its second rising clock edge after the request.
// - After grant, next falling core clock edge asserts power-down.
// - Power-down shuts flash, fast oscillator, filter and bandgap.
// - Wake interrupt is synchronised on a falling 32 kHz edge.
// - Next rising 32 kHz edge releases power-down.
// - Following rising 32 kHz edge samples supply comparators.
// - Next falling 32 kHz edge drops halt request; core then resumes.
// - Supply monitor is duty cycled during sleep per duty setting.
// - Sleep interrupt also fires periodically while awake.
// - Watchdog reset sets its flag; software can only clear it.
// - No watchdog reset while power-on flag is set; reset sets it.
module sws_sequencer
    import sws_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    // Register port
    input  wire logic [sws_pkg::SWS_AW-1:0] reg_addr,
    input  wire logic [sws_pkg::SWS_DW-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [sws_pkg::SWS_DW-1:0] reg_rdata,
    // Clocks from pins and oscillators
    input  wire logic                       lp_clk,
    input  wire logic                       core_clk,
    // Processor handshake
    input  wire logic                       halt_grant,
    input  wire logic                       irq_pending,
    output logic                            halt_request,
    output logic                            irq_defer,
    output logic                            core_clk_ext,
    // Power control and monitors
    input  wire logic                       ppor_cmp,
    input  wire logic                       lvd_cmp,
    output logic                            power_down,
    output logic                            lvd_on,
    // Events
    output logic                            sleep_irq,
    output logic                            wdt_reset
);
    import sws_pkg::*;

    // =====================================================
    // Reset release and input synchronisers
    logic       rst_meta_reg;
    logic       rst_n;
    logic [5:0] sync_q;
    logic [1:0] clk_dly_reg;
    logic       lp_s;
    logic       core_s;
    logic       grant_s;
    logic       irq_s;
    logic       ppor_s;
    logic       lvd_s;
    logic       lp_rise;
    logic       lp_fall;
    logic       core_rise;
    logic       core_fall;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    sws_sync #(
        .W (6)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .d       ({lvd_cmp, ppor_cmp, irq_pending, halt_grant,
                   core_clk, lp_clk}),
        .q       (sync_q)
    );

    assign lp_s    = sync_q[0];
    assign core_s  = sync_q[1];
    assign grant_s = sync_q[2];
    assign irq_s   = sync_q[3];
    assign ppor_s  = sync_q[4];
    assign lvd_s   = sync_q[5];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_dly_reg <= 2'h0;
        end else if (ce) begin
            clk_dly_reg <= {core_s, lp_s};
        end
    end

    assign lp_rise   = lp_s & ~clk_dly_reg[0];
    assign lp_fall   = ~lp_s & clk_dly_reg[0];
    assign core_rise = core_s & ~clk_dly_reg[1];
    assign core_fall = ~core_s & clk_dly_reg[1];

    // =====================================================
    // Helpers
    function automatic logic [SWS_ST_W-1:0] st_tc(input logic [1:0] sel);
        case (sel)
            2'h0:    st_tc = SWS_ST_TC0;
            2'h1:    st_tc = SWS_ST_TC1;
            2'h2:    st_tc = SWS_ST_TC2;
            default: st_tc = SWS_ST_TC3;
        endcase
    endfunction

    function automatic logic [SWS_DUTY_W-1:0] duty_p(input logic [1:0] sel);
        case (sel)
            2'h0:    duty_p = SWS_DUTY_P0;
            2'h1:    duty_p = SWS_DUTY_P1;
            2'h2:    duty_p = SWS_DUTY_P2;
            default: duty_p = SWS_DUTY_P3;
        endcase
    endfunction

    // =====================================================
    // Register decode
    sws_state_t          state_reg;
    logic                wr_scr;
    logic                wr_wdc;
    logic                wr_trim;
    logic                wr_osc;
    logic                power_on_flag_reg;
    logic                watchdog_reset_flag_reg;
    logic                sleep_reg;
    logic                stop_reg;
    logic [1:0]          trim_reg;
    logic [1:0]          period_reg;
    logic [1:0]          wd_reg;
    logic [SWS_ST_W-1:0] st_reg;
    logic [1:0]          cmp_reg;
    logic                overflow;
    logic                wd_fire;

    assign wr_scr  = reg_wr && (reg_addr == SWS_SCR_ADDR);
    assign wr_wdc  = reg_wr && (reg_addr == SWS_WDC_ADDR);
    assign wr_trim = reg_wr && (reg_addr == SWS_TRIM_ADDR);
    assign wr_osc  = reg_wr && (reg_addr == SWS_OSC_ADDR);

    // =====================================================
    // Status flags and control bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_on_flag_reg <= 1'b1;
        end else if (ce && wr_scr && !reg_wdata[SWS_SCR_POWER_ON_FLAG]) begin
            power_on_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_reset_flag_reg <= 1'b0;
        end else if (ce) begin
            if (wd_fire) begin
                watchdog_reset_flag_reg <= 1'b1;
            end else if (wr_scr && !reg_wdata[SWS_SCR_WATCHDOG_RESET_FLAG]) begin
                watchdog_reset_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_reg   <= 1'b0;
            trim_reg   <= 2'h0;
            period_reg <= 2'h0;
        end else if (ce) begin
            if (wr_scr) begin
                stop_reg <= reg_wdata[SWS_SCR_STOP];
            end
            if (wr_trim) begin
                trim_reg <= reg_wdata[SWS_TRIM_LO +: 2];
            end
            if (wr_osc) begin
                period_reg <= reg_wdata[1:0];
            end
        end
    end

    // =====================================================
    // Sleep timer and watchdog
    assign overflow = lp_rise && (st_reg == st_tc(period_reg));
    assign wd_fire  = overflow && !power_on_flag_reg && !wr_wdc
                      && (wd_reg == SWS_WD_LIMIT - 2'h1);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (ce) begin
            if (wd_fire) begin
                st_reg <= '0;
            end else if (wr_wdc && reg_wdata == SWS_FULL_CLEAR) begin
                st_reg <= '0;
            end else if (overflow) begin
                st_reg <= '0;
            end else if (lp_rise) begin
                st_reg <= st_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_reg <= 2'h0;
        end else if (ce) begin
            if (wr_wdc || wd_fire || power_on_flag_reg) begin
                wd_reg <= 2'h0;
            end else if (overflow) begin
                wd_reg <= wd_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_irq <= 1'b0;
            wdt_reset <= 1'b0;
        end else if (ce) begin
            sleep_irq <= overflow;
            wdt_reset <= wd_fire;
        end
    end

    // =====================================================
    // Sleep and wake sequence
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SWS_RUN;
        end else if (ce) begin
            if (wd_fire) begin
                state_reg <= SWS_RUN;
            end else begin
                case (state_reg)
                    SWS_RUN: begin
                        if (wr_scr && reg_wdata[SWS_SCR_SLEEP]) begin
                            state_reg <= SWS_REQ;
                        end
                    end
                    SWS_REQ: begin
                        if (grant_s) begin
                            state_reg <= SWS_GRANT;
                        end
                    end
                    SWS_GRANT: begin
                        if (core_fall) begin
                            state_reg <= SWS_SLEEP;
                        end
                    end
                    SWS_SLEEP: begin
                        // Stop bit set keeps the part asleep
                        if (irq_s && !stop_reg && lp_fall) begin
                            state_reg <= SWS_SYNC;
                        end
                    end
                    SWS_SYNC: begin
                        if (lp_rise) begin
                            state_reg <= SWS_SETTLE;
                        end
                    end
                    SWS_SETTLE: begin
                        if (lp_rise) begin
                            state_reg <= SWS_RECOVER;
                        end
                    end
                    SWS_RECOVER: begin
                        if (lp_fall) begin
                            state_reg <= SWS_RELEASE;
                        end
                    end
                    SWS_RELEASE: begin
                        if (!grant_s) begin
                            state_reg <= SWS_RUN;
                        end
                    end
                    default: begin
                        state_reg <= SWS_RUN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_reg <= 1'b0;
        end else if (ce) begin
            if (wd_fire || (state_reg == SWS_RELEASE && !grant_s)) begin
                sleep_reg <= 1'b0;
            end else if (state_reg == SWS_RUN && wr_scr
                         && reg_wdata[SWS_SCR_SLEEP]) begin
                sleep_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_request <= 1'b0;
        end else if (ce) begin
            if (wd_fire || (state_reg == SWS_RECOVER && lp_fall)) begin
                halt_request <= 1'b0;
            end else if (state_reg == SWS_RUN && wr_scr
                         && reg_wdata[SWS_SCR_SLEEP]) begin
                halt_request <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down <= 1'b0;
        end else if (ce) begin
            if (wd_fire || (state_reg == SWS_SYNC && lp_rise)) begin
                power_down <= 1'b0;
            end else if (state_reg == SWS_GRANT && core_fall) begin
                power_down <= 1'b1;
            end
        end
    end

    // Comparators captured once settled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_reg <= 2'h0;
        end else if (ce && state_reg == SWS_SETTLE && lp_rise) begin
            cmp_reg <= {lvd_s, ppor_s};
        end
    end

    // Forced back to the internal clock on entry
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_clk_ext <= 1'b0;
        end else if (ce) begin
            if (state_reg == SWS_GRANT && core_fall) begin
                core_clk_ext <= 1'b0;
            end else if (wr_osc) begin
                core_clk_ext <= reg_wdata[SWS_OSC_EXT];
            end
        end
    end

    // Holds interrupts until one core edge after grant drops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_defer <= 1'b0;
        end else if (ce) begin
            if (state_reg == SWS_SYNC) begin
                irq_defer <= 1'b1;
            end else if (state_reg == SWS_RUN && core_rise) begin
                irq_defer <= 1'b0;
            end
        end
    end

    // =====================================================
    // Supply monitor duty cycling
    logic [SWS_DUTY_W-1:0] duty_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_reg <= '0;
            lvd_on   <= 1'b1;
        end else if (ce) begin
            if (!power_down) begin
                duty_reg <= '0;
                lvd_on   <= 1'b1;
            end else if (lp_rise) begin
                if (duty_reg >= duty_p(trim_reg)) begin
                    duty_reg <= '0;
                end else begin
                    duty_reg <= duty_reg + 1'b1;
                end
                lvd_on <= (duty_reg == '0);
            end
        end
    end

    // =====================================================
    // Read port
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= SWS_ZERO_BYTE;
        end else if (ce) begin
            reg_rdata <= SWS_ZERO_BYTE;
            if (reg_rd) begin
                case (reg_addr)
                    SWS_SCR_ADDR: begin
                        reg_rdata[SWS_SCR_WATCHDOG_RESET_FLAG]  <= watchdog_reset_flag_reg;
                        reg_rdata[SWS_SCR_POWER_ON_FLAG]  <= power_on_flag_reg;
                        reg_rdata[SWS_SCR_SLEEP] <= sleep_reg;
                        reg_rdata[SWS_SCR_STOP]  <= stop_reg;
                    end
                    SWS_CMP_ADDR: begin
                        reg_rdata[1:0] <= cmp_reg;
                    end
                    SWS_TRIM_ADDR: begin
                        reg_rdata[SWS_TRIM_LO +: 2] <= trim_reg;
                    end
                    SWS_OSC_ADDR: begin
                        reg_rdata[1:0]         <= period_reg;
                        reg_rdata[SWS_OSC_EXT] <= core_clk_ext;
                    end
                    SWS_STAT_ADDR: begin
                        reg_rdata[2:0]                <= state_reg;
                        reg_rdata[3]                  <= power_down;
                        reg_rdata[SWS_STAT_WD_LO +: 2] <= wd_reg;
                    end
                    default: begin
                        reg_rdata <= SWS_ZERO_BYTE;
                    end
                endcase
            end
        end
    end

endmodule

// ### logic/sws_pkg.sv
// Constants and types shared by the sleep/wake/watchdog sequencer
package sws_pkg;

    // =====================================================
    // Register port
    localparam int          SWS_AW         = 9;
    localparam int          SWS_DW         = 8;
    localparam logic [8:0]  SWS_WDC_ADDR   = 9'h0E3;
    localparam logic [8:0]  SWS_SCR_ADDR   = 9'h0FF;
    localparam logic [8:0]  SWS_CMP_ADDR   = 9'h1E4;
    localparam logic [8:0]  SWS_TRIM_ADDR  = 9'h1EB;
    localparam logic [8:0]  SWS_OSC_ADDR   = 9'h1F0;
    localparam logic [8:0]  SWS_STAT_ADDR  = 9'h1F1;

    // =====================================================
    // Field positions
    localparam int          SWS_SCR_WATCHDOG_RESET_FLAG   = 5;
    localparam int          SWS_SCR_POWER_ON_FLAG   = 4;
    localparam int          SWS_SCR_SLEEP  = 3;
    localparam int          SWS_SCR_STOP   = 0;
    localparam int          SWS_OSC_EXT    = 2;
    localparam int          SWS_TRIM_LO    = 6;
    localparam int          SWS_STAT_WD_LO = 4;

    // =====================================================
    // Values
    localparam logic [7:0]  SWS_FULL_CLEAR = 8'h38;
    localparam logic [1:0]  SWS_WD_LIMIT   = 2'h3;
    localparam logic [7:0]  SWS_ZERO_BYTE  = 8'h00;

    // Sleep timer terminal counts in 32 kHz periods, per period select
    localparam int          SWS_ST_W       = 15;
    localparam logic [14:0] SWS_ST_TC0     = 15'h003F;
    localparam logic [14:0] SWS_ST_TC1     = 15'h01FF;
    localparam logic [14:0] SWS_ST_TC2     = 15'h0FFF;
    localparam logic [14:0] SWS_ST_TC3     = 15'h7FFF;

    // Monitor duty periods in 32 kHz periods, per duty select
    localparam int          SWS_DUTY_W     = 9;
    localparam logic [8:0]  SWS_DUTY_P0    = 9'h07F;
    localparam logic [8:0]  SWS_DUTY_P1    = 9'h1FF;
    localparam logic [8:0]  SWS_DUTY_P2    = 9'h01F;
    localparam logic [8:0]  SWS_DUTY_P3    = 9'h007;

    // =====================================================
    // Sequencer states
    typedef enum logic [2:0] {
        SWS_RUN     = 3'b000,
        SWS_REQ     = 3'b001,
        SWS_GRANT   = 3'b010,
        SWS_SLEEP   = 3'b011,
        SWS_SYNC    = 3'b100,
        SWS_SETTLE  = 3'b101,
        SWS_RECOVER = 3'b110,
        SWS_RELEASE = 3'b111
    } sws_state_t;

endpackage

// ### logic/sws_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps

module sws_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else if (ce) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// ### sim/sws_sequencer_chk.sv
// Assertion checker for the sleep/wake/watchdog sequencer
`timescale 1ns/1ps

module sws_sequencer_chk
    import sws_pkg::*;
(
    // Clock and reset
    input wire logic                       sys_clk,
    input wire logic                       rstn,
    input wire logic                       ce,
    // Register port
    input wire logic [sws_pkg::SWS_AW-1:0] reg_addr,
    input wire logic [sws_pkg::SWS_DW-1:0] reg_wdata,
    input wire logic                       reg_wr,
    // Handshake, power and events
    input wire logic                       halt_grant,
    input wire logic                       halt_request,
    input wire logic                       irq_defer,
    input wire logic                       core_clk_ext,
    input wire logic                       power_down,
    input wire logic                       sleep_irq,
    input wire logic                       wdt_reset
);
    logic por_flag_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ==================================================
    // Software view of the power-on flag
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            por_flag_reg <= 1'b1;
        end else if (ce && reg_wr && reg_addr == SWS_SCR_ADDR &&
                     !reg_wdata[SWS_SCR_POWER_ON_FLAG]) begin
            por_flag_reg <= 1'b0;
        end
    end

    // ==================================================
    // Register writes
    sequence s_scr_wr;
        ce && reg_wr && reg_addr == SWS_SCR_ADDR;
    endsequence
    sequence s_wdc_wr;
        ce && reg_wr && reg_addr == SWS_WDC_ADDR;
    endsequence

    // ==================================================
    // Properties
    sleep_req_a:
        assert property (s_scr_wr ##0 reg_wdata[SWS_SCR_SLEEP] &&
            !halt_request && !irq_defer && !power_down |=> halt_request)
        else $error("sleep write did not raise halt request");
    halt_cause_a:
        assert property ($rose(halt_request) |->
            $past(reg_wr) && $past(reg_addr) == SWS_SCR_ADDR)
        else $error("halt request rose without sleep write");
    pd_entry_a:
        assert property ($rose(power_down) |-> halt_request && halt_grant)
        else $error("power down without granted halt");
    clk_int_a:
        assert property (power_down |-> !core_clk_ext)
        else $error("core clock external during power down");
    pd_exit_a:
        assert property ($fell(power_down) && !wdt_reset |-> halt_request)
        else $error("power down released after halt request");
    req_drop_a:
        assert property ($fell(halt_request) && !wdt_reset |->
            !power_down && irq_defer)
        else $error("halt request dropped out of order");
    wdt_pulse_a:
        assert property (wdt_reset |=>
            !wdt_reset && !halt_request && !power_down)
        else $error("watchdog reset not a clean abort pulse");
    irq_pulse_a:
        assert property (sleep_irq |=> !sleep_irq)
        else $error("sleep interrupt longer than one cycle");
    clr_full_a:
        assert property (s_wdc_wr ##0 reg_wdata == SWS_FULL_CLEAR |=>
            ##1 !sleep_irq [*8])
        else $error("sleep timer not cleared by full clear");
    clr_wd_a:
        assert property (s_wdc_wr |=> !wdt_reset [*8])
        else $error("watchdog fired right after clear");
    por_hold_a:
        assert property (por_flag_reg |-> !wdt_reset)
        else $error("watchdog fired with power-on flag set");
endmodule

bind sws_sequencer sws_sequencer_chk u_chk (
    .sys_clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .halt_grant,
    .halt_request, .irq_defer, .core_clk_ext, .power_down, .sleep_irq,
    .wdt_reset
);

// ### sim/sws_cpu_model.sv
// Behavioural processor core behind the halt handshake
`timescale 1ns/1ps

module sws_cpu_model #(
    parameter int HALF_NS = 60
) (
    // Handshake
    input  wire logic halt_request,
    input  wire logic power_down,
    output logic      halt_grant,
    // Core clock
    output logic      core_clk
);
    logic req_seen;

    // Core clock stands still while powered down
    initial begin
        core_clk = 1'b0;
        forever begin
            #(HALF_NS);
            if (power_down !== 1'b1) begin
                core_clk = ~core_clk;
            end
        end
    end

    initial begin
        req_seen   = 1'b0;
        halt_grant = 1'b0;
    end

    // Grant one edge after the request is sampled, drop on next edge
    always @(posedge core_clk) begin
        req_seen   <= halt_request;
        halt_grant <= halt_request && req_seen;
    end
endmodule

// ### sim/testbench.sv
// Self-checking testbench for the sleep/wake/watchdog sequencer
`timescale 1ns/1ps

module testbench;
    import sws_pkg::*;

    // Low-speed clock period in sys_clk cycles, sped up for run length
    localparam int LP = 16;

    logic              sys_clk, rstn, ce, reg_wr, reg_rd, lp_clk;
    logic [SWS_AW-1:0] reg_addr;
    logic [SWS_DW-1:0] reg_wdata, reg_rdata;
    logic              core_clk, halt_grant, irq_pending, halt_request;
    logic              irq_defer, core_clk_ext, ppor_cmp, lvd_cmp;
    logic              power_down, lvd_on, sleep_irq, wdt_reset;
    int                n_fail, total_checks, wd, cyc;
    wire  [4:0]        mon;

    assign mon = {wdt_reset, sleep_irq, halt_grant, power_down, halt_request};

    sws_sequencer u_dut (
        .sys_clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .lp_clk, .core_clk, .halt_grant, .irq_pending,
        .halt_request, .irq_defer, .core_clk_ext, .ppor_cmp, .lvd_cmp,
        .power_down, .lvd_on, .sleep_irq, .wdt_reset
    );
    sws_cpu_model u_cpu (.halt_request, .power_down, .halt_grant, .core_clk);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        lp_clk = 1'b0;
        forever #(LP * 10) lp_clk = ~lp_clk;
    end

    // ==================================================
    // Tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic wait_ev(input int s, input logic v, input int lim);
        cyc = 0;
        #1;
        while (mon[s] !== v && cyc < lim) begin
            @(posedge sys_clk);
            #1;
            cyc++;
        end
        check({7'h0, mon[s]}, {7'h0, v});
    endtask
    task automatic watch(input int irqs);
        int k;
        k   = 0;
        wd  = 0;
        cyc = 0;
        while (k < irqs && cyc < 6000) begin
            @(posedge sys_clk);
            #1;
            cyc++;
            k  += int'(sleep_irq === 1'b1);
            wd += int'(wdt_reset === 1'b1);
        end
        check(8'(k), 8'(irqs));
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic stop_test;
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==================================================
    // Main sequence
    initial begin
        rstn = 0; ce = 1; reg_wr = 0; reg_rd = 0; reg_addr = '0;
        reg_wdata = '0; irq_pending = 0; ppor_cmp = 0; lvd_cmp = 1;
        n_fail = 0; total_checks = 0;
        do_reset();
        check({7'h0, lvd_on}, 8'h01);
        rd(SWS_SCR_ADDR, 8'h10);
        rd(SWS_WDC_ADDR, 8'h00);
        rd(9'h000, 8'h00);
        watch(1);
        check(8'(cyc >= 62 * LP && cyc <= 64 * LP), 8'h01);
        watch(3);
        check(8'(wd), 8'h00);
        repeat (30 * LP) @(posedge sys_clk);
        wr(SWS_WDC_ADDR, SWS_FULL_CLEAR);
        watch(1);
        check(8'(cyc >= 63 * LP && cyc <= 65 * LP), 8'h01);
        watch(1);
        check(8'(cyc >= 63 * LP && cyc <= 65 * LP), 8'h01);
        wr(SWS_SCR_ADDR, 8'h00);
        rd(SWS_SCR_ADDR, 8'h00);
        repeat (4) begin
            watch(1);
            check(8'(wd), 8'h00);
            wr(SWS_WDC_ADDR, 8'hA5);
        end
        wr(SWS_WDC_ADDR, SWS_FULL_CLEAR);
        watch(4);
        check(8'(wd), 8'h01);
        rd(SWS_SCR_ADDR, 8'h20);
        wr(SWS_SCR_ADDR, 8'h30);
        rd(SWS_SCR_ADDR, 8'h20);
        wr(SWS_SCR_ADDR, 8'h00);
        rd(SWS_SCR_ADDR, 8'h00);
        wr(SWS_SCR_ADDR, 8'h20);
        rd(SWS_SCR_ADDR, 8'h00);
        // Sleep entry from external clock, then wake
        wr(SWS_WDC_ADDR, SWS_FULL_CLEAR);
        wr(SWS_OSC_ADDR, 8'h04);
        wr(SWS_SCR_ADDR, 8'h08);
        #1 check({7'h0, halt_request}, 8'h01);
        wait_ev(1, 1'b1, 200);
        check({7'h0, core_clk_ext}, 8'h00);
        repeat (100) @(posedge sys_clk);
        check({7'h0, halt_request}, 8'h01);
        check({7'h0, lvd_on}, 8'h00);
        irq_pending <= 1'b1;
        wait_ev(1, 1'b0, 4 * LP);
        wait_ev(0, 1'b0, 4 * LP);
        check(8'(cyc > LP && cyc <= 2 * LP), 8'h01);
        check({7'h0, irq_defer}, 8'h01);
        @(posedge sys_clk);
        irq_pending <= 1'b0;
        wait_ev(2, 1'b0, 50);
        repeat (4) @(posedge sys_clk);
        rd(SWS_SCR_ADDR, 8'h00);
        rd(SWS_CMP_ADDR, 8'h02);
        rd(SWS_OSC_ADDR, 8'h00);
        @(posedge sys_clk);
        do_reset();
        rd(SWS_SCR_ADDR, 8'h10);
        watch(4);
        check(8'(wd), 8'h00);
        stop_test();
    end

    initial begin
        #1_000_000;
        n_fail++;
        stop_test();
    end
endmodule
